// >>> rtl/dpl_top.sv
// Drive protection supervisor: overload, stall, phase loss, trips, command loss.
// Assumes synchronous inputs; current given as percent of motor rated current.
// Functional notes
// - Warning threshold percent of rated, 30-150, default 150
// - Collector function 5 drives overload warning
// - Overload trip cuts output after trip delay
// - Stall bit 0: accelerating turns to decelerating
// - Stall bit 1: constant run decelerates
// - Stall bit 2: DC link high halts decel
// - Stall threshold percent of rated, 30-200
// - Stall select three independent phase enables
// - Function 7 reports stall even when disabled
// - Stall intervention may stretch ramp times
// - Phase-loss select: none, output, input, both
// - Output phase loss shuts output off
// - Input phase loss or capacitor wear blocks
// - Input function 18 trips when closed
// - Input function 19 trips when open
// - Drive overload alarm on function 6
// - Analog loss criterion: off, half, minimum
// - Voltage-plus-current mode: either input low
// - After loss wait, continue, coast, or decelerate
// - Function 11 signals command loss
`timescale 1ns/10ps
module dpl_top #(
    parameter int TICK_CYCLES = dpl_pkg::TICK_CYCLES,
    parameter logic [7:0] WARN_LEVEL_RESET = dpl_pkg::WARN_LEVEL_DEF,
    parameter logic [7:0] STALL_LEVEL_RESET = dpl_pkg::STALL_LEVEL_DEF
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [7:0] motor_current_pct_i,
    input wire logic drive_current_over_rated_i,
    input wire logic [1:0] run_phase_i,
    input wire logic dc_link_high_i,
    input wire logic [2:0] output_phase_lost_i,
    input wire logic [2:0] input_phase_lost_i,
    input wire logic capacitor_worn_i,
    input wire logic [7:0] overload_warn_threshold_i,
    input wire logic [9:0] overload_warn_delay_i,
    input wire logic overload_trip_enable_i,
    input wire logic [7:0] overload_trip_threshold_i,
    input wire logic [9:0] overload_trip_delay_i,
    input wire logic [2:0] stall_phase_enables_i,
    input wire logic [7:0] stall_current_threshold_i,
    input wire logic [1:0] phase_loss_protect_select_i,
    input wire logic [4:0] collector_output_function_i,
    input wire logic [4:0] relay_output_function_i,
    input wire logic [4:0] seventh_input_function_i,
    input wire logic [4:0] eighth_input_function_i,
    input wire logic seventh_digital_input_i,
    input wire logic eighth_digital_input_i,
    input wire logic [1:0] analog_loss_criterion_i,
    input wire logic [1:0] command_loss_action_i,
    input wire logic [10:0] command_loss_wait_i,
    input wire dpl_pkg::dpl_cmd_s cmd_i,
    input wire logic fault_clear_i,
    output logic output_enable_o,
    output logic fault_display_o,
    output logic force_decel_o,
    output logic hold_decel_o,
    output logic ramp_stretch_o,
    output logic hold_last_freq_o,
    output logic decel_to_stop_o,
    output logic open_collector_output_o,
    output logic relay_contact_output_o,
    output dpl_pkg::dpl_events_s events_o
);
    typedef struct packed {
        logic [23:0] tick_count;
        logic tick;
        dpl_pkg::dpl_events_s ev;
        logic trip_latched;
        logic decel_latched;
        logic oc_out;
        logic relay_out;
        logic force_decel;
        logic hold_decel;
        logic hold_last;
    } dpl_state_s;

    dpl_state_s state_reg;
    dpl_state_s state_next;
    logic warn_expired;
    logic trip_expired;
    logic loss_expired;
    logic warn_over;
    logic trip_over;
    logic loss_now;
    logic [7:0] warn_level;
    logic [7:0] stall_level;
    logic [9:0] warn_delay;
    logic [10:0] loss_wait;

    // Clamp a setting into its permitted window
    function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
        if (v < lo)
        begin
            return lo;
        end
        else if (v > hi)
        begin
            return hi;
        end
        return v;
    endfunction

    // Map an event to an output whose function code selects it
    function automatic logic route(input logic [4:0] fn, input dpl_pkg::dpl_events_s ev);
        case (fn)
            dpl_pkg::OUT_FN_OVERLOAD: return ev.overload_warn_flag;
            dpl_pkg::OUT_FN_DRIVE_OVL: return ev.drive_overload;
            dpl_pkg::OUT_FN_STALL: return ev.stall_active;
            dpl_pkg::OUT_FN_CMD_LOSS: return ev.cmd_loss;
            default: return 1'b0;
        endcase
    endfunction

    // Analog loss test under the selected criterion
    function automatic logic below_min(input logic [1:0] crit, input logic [7:0] val,
                                       input logic [7:0] minv);
        case (crit)
            2'h1: return val < {1'b0, minv[7:1]};
            2'h2: return val < minv;
            default: return 1'b0;
        endcase
    endfunction

    assign warn_level = clamp8(overload_warn_threshold_i, dpl_pkg::WARN_LEVEL_MIN,
                               dpl_pkg::WARN_LEVEL_MAX);
    assign stall_level = clamp8(stall_current_threshold_i, dpl_pkg::STALL_LEVEL_MIN,
                                dpl_pkg::STALL_LEVEL_MAX);
    assign warn_delay = (overload_warn_delay_i > dpl_pkg::WARN_TIME_MAX) ?
                        dpl_pkg::WARN_TIME_MAX : overload_warn_delay_i;
    assign loss_wait = (command_loss_wait_i < dpl_pkg::LOSS_WAIT_MIN) ? dpl_pkg::LOSS_WAIT_MIN :
                       (command_loss_wait_i > dpl_pkg::LOSS_WAIT_MAX) ? dpl_pkg::LOSS_WAIT_MAX :
                       command_loss_wait_i;
    assign warn_over = motor_current_pct_i > warn_level;
    assign trip_over = overload_trip_enable_i && (motor_current_pct_i > overload_trip_threshold_i);

    always_comb
    begin
        loss_now = below_min(analog_loss_criterion_i, cmd_i.voltage_analog_input,
                             cmd_i.voltage_min) || !cmd_i.comm_cmd_valid;
        if (cmd_i.freq_source == dpl_pkg::FREQ_SRC_V_PLUS_I)
        begin
            loss_now = loss_now || below_min(analog_loss_criterion_i,
                                             cmd_i.current_analog_input,
                                             cmd_i.current_min);
        end
    end

    dpl_timer #(.WIDTH(11)) u_warn_timer (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .tick_i(state_reg.tick),
        .cond_i(warn_over),
        .limit_i({1'b0, warn_delay}),
        .expired_o(warn_expired)
    );

    dpl_timer #(.WIDTH(11)) u_trip_timer (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .tick_i(state_reg.tick),
        .cond_i(trip_over),
        .limit_i({1'b0, overload_trip_delay_i}),
        .expired_o(trip_expired)
    );

    dpl_timer #(.WIDTH(11)) u_loss_timer (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .tick_i(state_reg.tick),
        .cond_i(loss_now),
        .limit_i(loss_wait),
        .expired_o(loss_expired)
    );

    always_comb
    begin
        logic stall_cur;
        logic pl_out;
        logic pl_in;
        logic ext;
        logic trip_now;
        stall_cur = motor_current_pct_i > stall_level;
        pl_out = 1'b0;
        pl_in = 1'b0;
        ext = 1'b0;
        trip_now = 1'b0;
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (state_reg.tick_count >= 24'(TICK_CYCLES - 1))
        begin
            state_next.tick_count = '0;
            state_next.tick = 1'b1;
        end
        else
        begin
            state_next.tick_count = state_reg.tick_count + 24'h000001;
        end
        // Stall control per run phase
        state_next.force_decel = 1'b0;
        state_next.hold_decel = 1'b0;
        case (dpl_pkg::dpl_run_phase_e'(run_phase_i))
            dpl_pkg::DPL_RUN_ACCEL:
            begin
                state_next.force_decel = stall_cur &&
                                         stall_phase_enables_i[dpl_pkg::STALL_ACC_BIT];
            end
            dpl_pkg::DPL_RUN_CONST:
            begin
                state_next.force_decel = stall_cur &&
                                         stall_phase_enables_i[dpl_pkg::STALL_CONST_BIT];
            end
            dpl_pkg::DPL_RUN_DECEL:
            begin
                state_next.hold_decel = dc_link_high_i &&
                                        stall_phase_enables_i[dpl_pkg::STALL_DEC_BIT];
            end
            default:
            begin
                state_next.force_decel = 1'b0;
            end
        endcase
        // Stall status regardless of enables
        state_next.ev.stall_active = stall_cur ||
                                     (dc_link_high_i && run_phase_i == 2'(dpl_pkg::DPL_RUN_DECEL));
        case (dpl_pkg::dpl_phase_loss_e'(phase_loss_protect_select_i))
            dpl_pkg::DPL_PL_OUTPUT:
            begin
                pl_out = 1'b1;
            end
            dpl_pkg::DPL_PL_INPUT:
            begin
                pl_in = 1'b1;
            end
            dpl_pkg::DPL_PL_BOTH:
            begin
                pl_out = 1'b1;
                pl_in = 1'b1;
            end
            default:
            begin
                pl_out = 1'b0;
            end
        endcase
        state_next.ev.phase_trip = (pl_out && |output_phase_lost_i) ||
                                   (pl_in && (|input_phase_lost_i || capacitor_worn_i));
        if (seventh_input_function_i == dpl_pkg::IN_FN_TRIP_NO && seventh_digital_input_i)
        begin
            ext = 1'b1;
        end
        if (seventh_input_function_i == dpl_pkg::IN_FN_TRIP_NC && !seventh_digital_input_i)
        begin
            ext = 1'b1;
        end
        if (eighth_input_function_i == dpl_pkg::IN_FN_TRIP_NO && eighth_digital_input_i)
        begin
            ext = 1'b1;
        end
        if (eighth_input_function_i == dpl_pkg::IN_FN_TRIP_NC && !eighth_digital_input_i)
        begin
            ext = 1'b1;
        end
        state_next.ev.ext_trip = ext;
        state_next.ev.drive_overload = drive_current_over_rated_i;
        state_next.ev.overload_warn_flag = warn_expired;
        state_next.ev.overload_trip = trip_expired;
        state_next.ev.cmd_loss = loss_expired;
        // Latching trips; new trip beats a clear
        trip_now = trip_expired || state_next.ev.phase_trip || ext ||
                   (loss_expired && command_loss_action_i == 2'(dpl_pkg::DPL_LOSS_COAST));
        if (trip_now)
        begin
            state_next.trip_latched = 1'b1;
        end
        else if (fault_clear_i)
        begin
            state_next.trip_latched = 1'b0;
        end
        if (loss_expired && command_loss_action_i == 2'(dpl_pkg::DPL_LOSS_DECEL))
        begin
            state_next.decel_latched = 1'b1;
        end
        else if (fault_clear_i)
        begin
            state_next.decel_latched = 1'b0;
        end
        state_next.hold_last = loss_expired &&
                               command_loss_action_i == 2'(dpl_pkg::DPL_LOSS_CONTINUE);
        state_next.oc_out = route(collector_output_function_i, state_next.ev);
        state_next.relay_out = route(relay_output_function_i, state_next.ev);
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_reg <= '0;
        end
        else if (ce_i)
        begin
            state_reg <= state_next;
        end
    end

    assign output_enable_o = !state_reg.trip_latched;
    assign fault_display_o = state_reg.trip_latched;
    assign force_decel_o = state_reg.force_decel || state_reg.decel_latched;
    assign hold_decel_o = state_reg.hold_decel;
    assign ramp_stretch_o = state_reg.force_decel || state_reg.hold_decel;
    assign hold_last_freq_o = state_reg.hold_last;
    assign decel_to_stop_o = state_reg.decel_latched;
    assign open_collector_output_o = state_reg.oc_out;
    assign relay_contact_output_o = state_reg.relay_out;
    assign events_o = state_reg.ev;

    AST_TRIP_CUTS: assert property (@(posedge clock_i) disable iff (srst_i)
        (ce_i && trip_expired) |=> !output_enable_o)
        else $error("overload trip did not cut output");
    AST_OC_WARN: assert property (@(posedge clock_i) disable iff (srst_i)
        (ce_i && collector_output_function_i == 5'h05 && $stable(collector_output_function_i)
         && warn_expired) |=> open_collector_output_o)
        else $error("warning not routed to collector output");
    AST_ACC_STALL: assert property (@(posedge clock_i) disable iff (srst_i)
        (ce_i && run_phase_i == 2'b01 && stall_phase_enables_i[0] &&
         motor_current_pct_i > stall_level) |=> force_decel_o)
        else $error("stall in acceleration did not decelerate");
    AST_CONST_STALL: assert property (@(posedge clock_i) disable iff (srst_i)
        (ce_i && run_phase_i == 2'b10 && !stall_phase_enables_i[1] &&
         !state_reg.decel_latched && !(loss_expired && command_loss_action_i == 2'b10))
        |=> !force_decel_o)
        else $error("disabled constant stall still acted");
    AST_DEC_HOLD: assert property (@(posedge clock_i) disable iff (srst_i)
        (ce_i && run_phase_i == 2'b11 && stall_phase_enables_i[2] && dc_link_high_i)
        |=> hold_decel_o)
        else $error("deceleration not halted on high DC link");
    AST_OUT_PL: assert property (@(posedge clock_i) disable iff (srst_i)
        (ce_i && phase_loss_protect_select_i[0] && |output_phase_lost_i) |=> ##1 !output_enable_o)
        else $error("output phase loss did not cut output");
    AST_NO_TRIP: assert property (@(posedge clock_i) disable iff (srst_i)
        (ce_i && seventh_input_function_i == 5'h12 && seventh_digital_input_i)
        |=> ##1 fault_display_o)
        else $error("normally-open trip not shown");
    AST_NC_TRIP: assert property (@(posedge clock_i) disable iff (srst_i)
        (ce_i && eighth_input_function_i == 5'h13 && !eighth_digital_input_i)
        |=> ##1 !output_enable_o)
        else $error("normally-closed trip did not cut output");
    AST_WARN_LEVEL: assert property (@(posedge clock_i) disable iff (srst_i)
        warn_level >= 8'h1E && warn_level <= 8'h96)
        else $error("warning level out of range");
endmodule

// >>> rtl/dpl_pkg.sv
// Package for drive protection logic: codes, defaults, timing constants.
// Assumes a 100 MHz clock; times are in tenths of seconds.
package dpl_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TENTH_NS = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_CYCLES = TENTH_NS / CLK_PERIOD_NS;
    localparam logic [7:0] WARN_LEVEL_DEF = 8'h96;
    localparam logic [7:0] WARN_LEVEL_MIN = 8'h1E;
    localparam logic [7:0] WARN_LEVEL_MAX = 8'h96;
    localparam logic [9:0] WARN_TIME_DEF = 10'h064;
    localparam logic [9:0] WARN_TIME_MAX = 10'h12C;
    localparam logic [7:0] TRIP_LEVEL_DEF = 8'hB4;
    localparam logic [9:0] TRIP_TIME_DEF = 10'h258;
    localparam logic [9:0] TRIP_TIME_MAX = 10'h258;
    localparam logic [7:0] STALL_LEVEL_DEF = 8'h96;
    localparam logic [7:0] STALL_LEVEL_MIN = 8'h1E;
    localparam logic [7:0] STALL_LEVEL_MAX = 8'hC8;
    localparam logic [10:0] LOSS_WAIT_DEF = 11'h00A;
    localparam logic [10:0] LOSS_WAIT_MIN = 11'h001;
    localparam logic [10:0] LOSS_WAIT_MAX = 11'h4B0;
    localparam int STALL_ACC_BIT = 0;
    localparam int STALL_CONST_BIT = 1;
    localparam int STALL_DEC_BIT = 2;
    localparam logic [4:0] OUT_FN_OVERLOAD = 5'h05;
    localparam logic [4:0] OUT_FN_DRIVE_OVL = 5'h06;
    localparam logic [4:0] OUT_FN_STALL = 5'h07;
    localparam logic [4:0] OUT_FN_CMD_LOSS = 5'h0B;
    localparam logic [4:0] IN_FN_TRIP_NO = 5'h12;
    localparam logic [4:0] IN_FN_TRIP_NC = 5'h13;
    localparam logic [3:0] FREQ_SRC_V_PLUS_I = 4'h6;
    typedef enum logic [1:0] {
        DPL_PL_NONE = 2'b00,
        DPL_PL_OUTPUT = 2'b01,
        DPL_PL_INPUT = 2'b10,
        DPL_PL_BOTH = 2'b11
    } dpl_phase_loss_e;
    typedef enum logic [1:0] {
        DPL_LOSS_CONTINUE = 2'b00,
        DPL_LOSS_COAST = 2'b01,
        DPL_LOSS_DECEL = 2'b10
    } dpl_loss_action_e;
    typedef enum logic [1:0] {
        DPL_RUN_STOP = 2'b00,
        DPL_RUN_ACCEL = 2'b01,
        DPL_RUN_CONST = 2'b10,
        DPL_RUN_DECEL = 2'b11
    } dpl_run_phase_e;
    typedef struct packed {
        logic overload_warn_flag;
        logic overload_trip;
        logic stall_active;
        logic drive_overload;
        logic ext_trip;
        logic phase_trip;
        logic cmd_loss;
    } dpl_events_s;
    typedef struct packed {
        logic [7:0] voltage_analog_input;
        logic [7:0] current_analog_input;
        logic [7:0] voltage_min;
        logic [7:0] current_min;
        logic [3:0] freq_source;
        logic comm_cmd_valid;
    } dpl_cmd_s;
endpackage

// >>> rtl/dpl_timer.sv
// Over-threshold persistence timer counting tenths of a second.
// Assumes a shared tick enable one cycle wide every tenth of a second.
`timescale 1ns/10ps
module dpl_timer #(
    parameter int WIDTH = 11
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic cond_i,
    input wire logic [WIDTH-1:0] limit_i,
    output logic expired_o
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic expired;
    } dpl_timer_s;
    dpl_timer_s state_reg;
    dpl_timer_s state_next;

    always_comb
    begin
        state_next = state_reg;
        if (!cond_i)
        begin
            state_next.count = '0;
            state_next.expired = 1'b0;
        end
        else if (state_reg.count >= limit_i)
        begin
            state_next.expired = 1'b1;
        end
        else if (tick_i)
        begin
            state_next.count = state_reg.count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_reg <= '0;
        end
        else if (ce_i)
        begin
            state_reg <= state_next;
        end
    end

    assign expired_o = state_reg.expired;
endmodule

// >>> tb/dpl_plant.sv
// Far-side model: motor current sensing and the two trip contacts.
// Assumes the bench sets load and contact demands; sensing lags one clock.
`timescale 1ns/10ps
module dpl_plant #(
    parameter logic [7:0] DRIVE_RATED_PCT = 8'hA0
) (
    input wire logic clock_i,
    input wire logic [7:0] load_pct_i,
    input wire logic [1:0] contacts_i,
    output logic [7:0] motor_current_pct_o,
    output logic drive_current_over_rated_o,
    output logic seventh_digital_input_o,
    output logic eighth_digital_input_o
);
    // Drive rating versus motor rating, arbitrary
    always_ff @(posedge clock_i)
    begin
        motor_current_pct_o <= load_pct_i;
        drive_current_over_rated_o <= load_pct_i > DRIVE_RATED_PCT;
        seventh_digital_input_o <= contacts_i[0];
        eighth_digital_input_o <= contacts_i[1];
    end
endmodule

// >>> tb/dpl_top_test.sv
// Self-checking bench for the drive protection supervisor.
// Assumes dpl_plant as far side; tick shortened to 10 clocks.
`timescale 1ns/10ps
module dpl_top_test;
    logic clock_i, srst_i, trip_en, dc_high, cap_worn, fault_clear;
    logic [7:0] load, warn_lvl, trip_lvl, stall_lvl, cur;
    logic [9:0] warn_dly, trip_dly;
    logic [1:0] phase, pl_sel, crit, action, contacts;
    logic [2:0] stall_en, out_lost, in_lost;
    logic [4:0] oc_fn, rly_fn, fn7, fn8;
    logic [10:0] loss_wait;
    logic p7, p8, drv_ovl;
    dpl_pkg::dpl_cmd_s cmd;
    wire out_en, fault, f_dec, h_dec, stretch, h_last, d_stop, oc_out, rly_out;
    dpl_pkg::dpl_events_s ev;
    int mismatches = 0;
    int n_checks = 0;
    bit lost;
    bit pl_hit;

    dpl_plant dpl_plant_inst (.clock_i(clock_i), .load_pct_i(load), .contacts_i(contacts),
        .motor_current_pct_o(cur), .drive_current_over_rated_o(drv_ovl),
        .seventh_digital_input_o(p7), .eighth_digital_input_o(p8));
    dpl_top #(.TICK_CYCLES(10)) dpl_top_inst (.clock_i(clock_i), .srst_i(srst_i), .ce_i(1'b1),
        .motor_current_pct_i(cur), .drive_current_over_rated_i(drv_ovl),
        .run_phase_i(phase), .dc_link_high_i(dc_high), .output_phase_lost_i(out_lost),
        .input_phase_lost_i(in_lost), .capacitor_worn_i(cap_worn),
        .overload_warn_threshold_i(warn_lvl), .overload_warn_delay_i(warn_dly),
        .overload_trip_enable_i(trip_en), .overload_trip_threshold_i(trip_lvl),
        .overload_trip_delay_i(trip_dly), .stall_phase_enables_i(stall_en),
        .stall_current_threshold_i(stall_lvl), .phase_loss_protect_select_i(pl_sel),
        .collector_output_function_i(oc_fn), .relay_output_function_i(rly_fn),
        .seventh_input_function_i(fn7), .eighth_input_function_i(fn8),
        .seventh_digital_input_i(p7), .eighth_digital_input_i(p8),
        .analog_loss_criterion_i(crit), .command_loss_action_i(action),
        .command_loss_wait_i(loss_wait), .cmd_i(cmd), .fault_clear_i(fault_clear),
        .output_enable_o(out_en), .fault_display_o(fault), .force_decel_o(f_dec),
        .hold_decel_o(h_dec), .ramp_stretch_o(stretch), .hold_last_freq_o(h_last),
        .decel_to_stop_o(d_stop), .open_collector_output_o(oc_out),
        .relay_contact_output_o(rly_out), .events_o(ev));

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
        @(posedge clock_i);
    endtask

    // Expected command loss from criterion, reference mode and link state
    function automatic logic exp_loss(input dpl_pkg::dpl_cmd_s c, input logic [1:0] cr);
        logic [7:0] vmin;
        logic [7:0] imin;
        logic lo;
        vmin = (cr == 2'h1) ? {1'b0, c.voltage_min[7:1]} : c.voltage_min;
        imin = (cr == 2'h1) ? {1'b0, c.current_min[7:1]} : c.current_min;
        lo = c.voltage_analog_input < vmin;
        if (c.freq_source == dpl_pkg::FREQ_SRC_V_PLUS_I)
        begin
            lo = lo || c.current_analog_input < imin;
        end
        return !c.comm_cmd_valid || ((cr == 2'h1 || cr == 2'h2) && lo);
    endfunction

    task automatic sett(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask

    // Remove causes first, then clear the latched trip
    task automatic clr();
        repeat (4) @(posedge clock_i);
        fault_clear <= 1'b1;
        repeat (2) @(posedge clock_i);
        fault_clear <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask

    task automatic results();
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        results();
    end

    initial
    begin
        void'($urandom(32'h06CE));
        {trip_en, dc_high, cap_worn, fault_clear, contacts, out_lost, in_lost} = '0;
        {phase, pl_sel, crit, action, stall_en, oc_fn, rly_fn, fn7, fn8} = '0;
        load = 8'h00;
        warn_lvl = dpl_pkg::WARN_LEVEL_DEF;
        warn_dly = dpl_pkg::WARN_TIME_DEF;
        trip_lvl = dpl_pkg::TRIP_LEVEL_DEF;
        trip_dly = 10'h001;
        stall_lvl = dpl_pkg::STALL_LEVEL_DEF;
        loss_wait = 11'h001;
        cmd = '{8'hFF, 8'hFF, 8'h10, 8'h10, dpl_pkg::FREQ_SRC_V_PLUS_I, 1'b1};
        srst_i = 1'b1;
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        sett(1);
        chk({out_en, fault, ev}, 16'h0100);
        // Normally-open contact closes, then opens
        fn7 <= dpl_pkg::IN_FN_TRIP_NO;
        fn8 <= dpl_pkg::IN_FN_TRIP_NC;
        contacts <= 2'b11;
        sett(4);
        chk({ev.ext_trip, out_en, fault}, 16'h0005);
        contacts <= 2'b10;
        sett(4);
        chk({out_en, fault}, 16'h0001);
        clr();
        sett(0);
        chk({ev.ext_trip, out_en, fault}, 16'h0002);
        contacts <= 2'b00;
        sett(4);
        chk({ev.ext_trip, out_en, fault}, 16'h0005);
        contacts <= 2'b10;
        clr();
        // Stall and drive overload across enables and run phases
        load <= 8'hC8;
        dc_high <= 1'b1;
        oc_fn <= dpl_pkg::OUT_FN_DRIVE_OVL;
        rly_fn <= dpl_pkg::OUT_FN_STALL;
        for (int e = 0; e < 8; e++)
            for (int p = 1; p < 4; p++)
            begin
                stall_en <= e[2:0];
                phase <= p[1:0];
                sett(4);
                chk(f_dec, (p == 1 && e[0]) || (p == 2 && e[1]));
                sett(0);
                chk(h_dec, p == 3 && e[2]);
                sett(0);
                chk({rly_out, oc_out, out_en}, 16'h0007);
                sett(0);
                chk(stretch, (p == 1 && e[0]) || (p == 2 && e[1]) || (p == 3 && e[2]));
            end
        {load, dc_high, stall_en, phase} <= '0;
        // Phase-loss protection select against each loss kind
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 3; k++)
            begin
                pl_sel <= s[1:0];
                out_lost <= (k == 0) ? 3'b010 : 3'b000;
                in_lost <= (k == 1) ? 3'b100 : 3'b000;
                cap_worn <= k == 2;
                sett(4);
                pl_hit = (s[0] && k == 0) || (s[1] && k != 0);
                chk({ev.phase_trip, out_en}, {pl_hit, !pl_hit});
                {out_lost, in_lost, cap_worn} <= '0;
                clr();
            end
        // Overload warning: delay, routing, low clamp of threshold
        oc_fn <= dpl_pkg::OUT_FN_OVERLOAD;
        warn_lvl <= 8'h50;
        warn_dly <= 10'h002;
        load <= 8'h64;
        sett(8);
        chk(ev.overload_warn_flag, 1'b0);
        sett(40);
        chk({ev.overload_warn_flag, oc_out}, 16'h0003);
        warn_lvl <= 8'h0A;
        load <= 8'h14;
        sett(40);
        chk(ev.overload_warn_flag, 1'b0);
        // Overload trip, disabled then enabled
        load <= 8'hC8;
        sett(40);
        chk(out_en, 1'b1);
        trip_en <= 1'b1;
        sett(40);
        chk({ev.overload_trip, out_en, fault}, 16'h0005);
        load <= 8'h00;
        trip_en <= 1'b0;
        clr();
        // Communication loss with each recovery action
        oc_fn <= dpl_pkg::OUT_FN_CMD_LOSS;
        for (int a = 0; a < 3; a++)
        begin
            action <= a[1:0];
            cmd.comm_cmd_valid <= 1'b0;
            sett(40);
            chk({h_last, out_en, d_stop, oc_out}, {a == 0, a != 1, a == 2, 1'b1});
            cmd.comm_cmd_valid <= 1'b1;
            clr();
        end
        // Analog loss with and without voltage-plus-current mode, random with a boundary case
        action <= dpl_pkg::DPL_LOSS_CONTINUE;
        for (int n = 0; n < 10; n++)
        begin
            crit <= (n == 0) ? 2'h2 : 2'($urandom_range(0, 2));
            cmd.freq_source <= (n > 6) ? 4'h3 : dpl_pkg::FREQ_SRC_V_PLUS_I;
            cmd.voltage_min <= (n == 0) ? 8'h40 : 8'($urandom_range(30, 200)) & 8'hFE;
            cmd.current_min <= (n == 0) ? 8'h40 : 8'($urandom_range(30, 200)) & 8'hFE;
            cmd.voltage_analog_input <= (n == 0) ? 8'h40 : 8'($urandom);
            cmd.current_analog_input <= (n == 0) ? 8'h40 : 8'($urandom);
            sett(40);
            lost = exp_loss(cmd, crit);
            chk({h_last, oc_out}, {lost, lost});
            cmd.voltage_analog_input <= 8'hFF;
            cmd.current_analog_input <= 8'hFF;
            repeat (4) @(posedge clock_i);
        end
        results();
    end
endmodule
